// File: inc/mmbd_pkg.sv
// Shared constants and types for the memory map and bank decoder
package mmbd_pkg;
  localparam int PC_W        = 13;
  localparam int DADDR_W     = 9;
  localparam int GPR_DEPTH   = 128;
  localparam int GPR_IDX_W   = 7;
  localparam int PROG_WORDS  = 2048;
  localparam int INSTR_W     = 14;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] IRQ_VEC   = 13'h0004;
  // Core register offsets, bank 0 view; the bank 1 copy sits 80h above
  localparam logic [6:0] OFS_WINDOW = 7'h00;
  localparam logic [6:0] OFS_PCL    = 7'h02;
  localparam logic [6:0] OFS_STATUS = 7'h03;
  localparam logic [6:0] OFS_FSR    = 7'h04;
  localparam logic [6:0] OFS_INSTR_COUNTER_UPPER_LATCH = 7'h0a;
  localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0b;
  localparam logic [6:0] OFS_GPR_LO = 7'h20;
  localparam logic [6:0] OFS_B1_TOP = 7'h3f;
  localparam logic [6:0] GPR_B1_BASE = 7'h60;
  // Status bit positions
  localparam int ST_IRP  = 7;
  localparam int ST_BSH  = 6;
  localparam int ST_BSL  = 5;
  localparam int ST_TO   = 4;
  localparam int ST_PD   = 3;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  typedef enum logic [3:0] {
    MMBD_R_NONE, MMBD_R_WIN, MMBD_R_PCL, MMBD_R_STATUS, MMBD_R_FSR,
    MMBD_R_INSTR_COUNTER_UPPER_LATCH, MMBD_R_INTERRUPT_CONTROL, MMBD_R_GPR, MMBD_R_PERIPH
  } mmbd_region_t;

  typedef struct packed {
    mmbd_region_t         region;
    logic [GPR_IDX_W-1:0] gpr_idx;
  } mmbd_dec_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] offset;
    logic [7:0] wdata;
  } mmbd_dreq_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mmbd_periph_t;
endpackage : mmbd_pkg

// File: hdl/mmbd_gpr_ram.sv
// General purpose register storage, flip-flop array
`timescale 1ns/1ps
module mmbd_gpr_ram #(
  parameter int DEPTH = mmbd_pkg::GPR_DEPTH,
  parameter int IDX_W = mmbd_pkg::GPR_IDX_W
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_we,
  input  wire logic [IDX_W-1:0] i_idx,
  input  wire logic [7:0]       i_wdata,
  output logic      [7:0]       o_rdata
);
  logic [7:0] mem_r [DEPTH];

  // Cleared at reset so reads before first write are defined
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem_r[k] <= mmbd_pkg::BYTE_RST;
      end
    end else if (i_we && (int'(i_idx) < DEPTH)) begin
      mem_r[i_idx] <= i_wdata;
    end
  end

  assign o_rdata = (int'(i_idx) < DEPTH) ? mem_r[i_idx] : mmbd_pkg::BYTE_RST;
endmodule : mmbd_gpr_ram

// File: hdl/mmbd_top.sv
// Program counter, bank select and data address decode with core registers
`timescale 1ns/1ps
module mmbd_top #(
  parameter int PROG_WORDS = mmbd_pkg::PROG_WORDS
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_pc_inc,
  input  wire logic                      i_pc_jump,
  input  wire logic [10:0]               i_jump_target,
  input  wire logic                      i_irq_entry,
  input  wire logic                      i_flags_we,
  input  wire logic [2:0]                i_flags,
  input  wire logic [1:0]                i_to_pd,
  input  wire mmbd_pkg::mmbd_dreq_t      i_dreq,
  input  wire logic [7:0]                i_periph_rdata,
  output logic [mmbd_pkg::PC_W-1:0]      o_pc,
  output logic [$clog2(PROG_WORDS)-1:0]  o_prog_addr,
  output logic [7:0]                     o_rd_data,
  output logic [7:0]                     o_status,
  output logic [7:0]                     o_interrupt_control,
  output mmbd_pkg::mmbd_periph_t         o_periph
);
  localparam int PA_W = $clog2(PROG_WORDS);

  logic [12:0] pc_r;
  logic [7:0]  status_r;
  logic [7:0]  fsr_r;
  logic [7:0]  instr_counter_upper_latch_r;
  logic [7:0]  interrupt_control_r;
  logic [7:0]  rd_data_r;
  logic [7:0]  gpr_rdata;
  logic [7:0]  status_view;
  logic [8:0]  eff_addr;
  logic        indirect;
  mmbd_pkg::mmbd_dec_t dec;

  function automatic logic periph_here(input logic [7:0] a);
    unique case (a)
      8'h01, 8'h05, 8'h06, 8'h07, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12,
      8'h15, 8'h16, 8'h17, 8'h1e, 8'h1f, 8'h81, 8'h85, 8'h86, 8'h87, 8'h8c,
      8'h8e, 8'h92, 8'h9f: periph_here = 1'b1;
      default: periph_here = 1'b0;
    endcase
  endfunction : periph_here

  // Bank 1 RAM folds above the 96 bank 0 bytes
  function automatic mmbd_pkg::mmbd_dec_t decode(input logic [8:0] a);
    logic [6:0] ofs;
    ofs = a[6:0];
    decode.gpr_idx = '0;
    decode.region  = mmbd_pkg::MMBD_R_NONE;
    if (a[8] == 1'b0) begin
      unique case (ofs)
        mmbd_pkg::OFS_WINDOW: decode.region = mmbd_pkg::MMBD_R_WIN;
        mmbd_pkg::OFS_PCL:    decode.region = mmbd_pkg::MMBD_R_PCL;
        mmbd_pkg::OFS_STATUS: decode.region = mmbd_pkg::MMBD_R_STATUS;
        mmbd_pkg::OFS_FSR:    decode.region = mmbd_pkg::MMBD_R_FSR;
        mmbd_pkg::OFS_INSTR_COUNTER_UPPER_LATCH: decode.region = mmbd_pkg::MMBD_R_INSTR_COUNTER_UPPER_LATCH;
        mmbd_pkg::OFS_INTERRUPT_CONTROL: decode.region = mmbd_pkg::MMBD_R_INTERRUPT_CONTROL;
        default: begin
          if (ofs >= mmbd_pkg::OFS_GPR_LO) begin
            if (a[7] == 1'b0) begin
              decode.region  = mmbd_pkg::MMBD_R_GPR;
              decode.gpr_idx = ofs - mmbd_pkg::OFS_GPR_LO;
            end else if (ofs <= mmbd_pkg::OFS_B1_TOP) begin
              decode.region  = mmbd_pkg::MMBD_R_GPR;
              decode.gpr_idx = (ofs - mmbd_pkg::OFS_GPR_LO) + mmbd_pkg::GPR_B1_BASE;
            end
          end else if (periph_here(a[7:0])) begin
            decode.region = mmbd_pkg::MMBD_R_PERIPH;
          end
        end
      endcase
    end
  endfunction : decode

  assign indirect = (i_dreq.offset == mmbd_pkg::OFS_WINDOW);
  assign eff_addr = indirect ? {status_r[mmbd_pkg::ST_IRP], fsr_r}
                             : {status_r[mmbd_pkg::ST_BSH:mmbd_pkg::ST_BSL], i_dreq.offset};
  assign dec = decode(eff_addr);

  assign status_view = {status_r[7:5], i_to_pd, status_r[2:0]};

  mmbd_gpr_ram #(
    .DEPTH (mmbd_pkg::GPR_DEPTH),
    .IDX_W (mmbd_pkg::GPR_IDX_W)
  ) u_gpr (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_we      (i_dreq.wr && (dec.region == mmbd_pkg::MMBD_R_GPR)),
    .i_idx     (dec.gpr_idx),
    .i_wdata   (i_dreq.wdata),
    .o_rdata   (gpr_rdata)
  );

  // Vectors and priority: interrupt, jump, low byte write, step
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_r <= mmbd_pkg::RESET_VEC;
    end else if (i_irq_entry) begin
      pc_r <= mmbd_pkg::IRQ_VEC;
    end else if (i_pc_jump) begin
      pc_r <= {instr_counter_upper_latch_r[4:3], i_jump_target};
    end else if (i_dreq.wr && (dec.region == mmbd_pkg::MMBD_R_PCL)) begin
      pc_r <= {instr_counter_upper_latch_r[4:0], i_dreq.wdata};
    end else if (i_pc_inc) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  // Data write wins over ALU flag update in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      status_r <= mmbd_pkg::STATUS_RST;
    end else if (i_dreq.wr && (dec.region == mmbd_pkg::MMBD_R_STATUS)) begin
      status_r <= {i_dreq.wdata[7:5], status_r[4:3], i_dreq.wdata[2:0]};
    end else if (i_flags_we) begin
      status_r[2:0] <= i_flags;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fsr_r    <= mmbd_pkg::BYTE_RST;
      instr_counter_upper_latch_r <= mmbd_pkg::BYTE_RST;
      interrupt_control_r <= mmbd_pkg::BYTE_RST;
    end else if (i_dreq.wr) begin
      if (dec.region == mmbd_pkg::MMBD_R_FSR) begin
        fsr_r <= i_dreq.wdata;
      end
      if (dec.region == mmbd_pkg::MMBD_R_INSTR_COUNTER_UPPER_LATCH) begin
        instr_counter_upper_latch_r <= {3'h0, i_dreq.wdata[4:0]};
      end
      if (dec.region == mmbd_pkg::MMBD_R_INTERRUPT_CONTROL) begin
        interrupt_control_r <= i_dreq.wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rd_data_r <= mmbd_pkg::BYTE_RST;
    end else if (i_dreq.rd) begin
      unique case (dec.region)
        mmbd_pkg::MMBD_R_PCL:    rd_data_r <= pc_r[7:0];
        mmbd_pkg::MMBD_R_STATUS: rd_data_r <= status_view;
        mmbd_pkg::MMBD_R_FSR:    rd_data_r <= fsr_r;
        mmbd_pkg::MMBD_R_INSTR_COUNTER_UPPER_LATCH: rd_data_r <= instr_counter_upper_latch_r;
        mmbd_pkg::MMBD_R_INTERRUPT_CONTROL: rd_data_r <= interrupt_control_r;
        mmbd_pkg::MMBD_R_GPR:    rd_data_r <= gpr_rdata;
        mmbd_pkg::MMBD_R_PERIPH: rd_data_r <= i_periph_rdata;
        default:                 rd_data_r <= mmbd_pkg::BYTE_RST;
      endcase
    end
  end

  // Fetch bus independent of data port
  assign o_prog_addr    = pc_r[PA_W-1:0];
  assign o_pc           = pc_r;
  assign o_rd_data      = rd_data_r;
  assign o_status       = status_view;
  assign o_interrupt_control       = interrupt_control_r;
  assign o_periph.rd    = i_dreq.rd && (dec.region == mmbd_pkg::MMBD_R_PERIPH);
  assign o_periph.wr    = i_dreq.wr && (dec.region == mmbd_pkg::MMBD_R_PERIPH);
  assign o_periph.addr  = eff_addr[7:0];
  assign o_periph.wdata = i_dreq.wdata;

  AST_IRQ_VECTOR: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    i_irq_entry |=> (pc_r == 13'h0004))
    else $error("interrupt entry did not reach vector four");

  AST_FETCH_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pc_inc && !i_irq_entry && !i_pc_jump && !i_dreq.wr) |=> (pc_r == $past(pc_r) + 13'h0001))
    else $error("counter did not step by one");

  AST_WRAP: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pc_inc && !i_irq_entry && !i_pc_jump && !i_dreq.wr && (&pc_r[PA_W-1:0]))
      |=> (o_prog_addr == '0))
    else $error("fetch address did not wrap");

  AST_JUMP_LATCH: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_pc_jump && !i_irq_entry) |=> (pc_r[10:0] == $past(i_jump_target))
      && (pc_r[12:11] == $past(instr_counter_upper_latch_r[4:3])))
    else $error("jump did not take upper bits from latch");

  AST_PCL_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_dreq.wr && dec.region == mmbd_pkg::MMBD_R_PCL && !i_irq_entry && !i_pc_jump)
      |=> (pc_r == {$past(instr_counter_upper_latch_r[4:0]), $past(i_dreq.wdata)}))
    else $error("low byte write did not load full counter");

  AST_UNIMPL_ZERO: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_dreq.rd && (dec.region == mmbd_pkg::MMBD_R_NONE || dec.region == mmbd_pkg::MMBD_R_WIN))
      |=> (o_rd_data == 8'h00))
    else $error("unimplemented location read nonzero");

  AST_HIGH_BANK: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_dreq.rd && !indirect && status_r[mmbd_pkg::ST_BSH]) |=> (o_rd_data == 8'h00))
    else $error("bank two or three read nonzero");

  AST_MIRROR: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_dreq.rd && !indirect && !status_r[mmbd_pkg::ST_BSH]
      && i_dreq.offset == mmbd_pkg::OFS_FSR) |=> (o_rd_data == $past(fsr_r)))
    else $error("pointer not seen in both banks");

  AST_WINDOW: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
    (i_dreq.wr && indirect && fsr_r == 8'h84 && !status_r[mmbd_pkg::ST_IRP])
      |=> (fsr_r == $past(i_dreq.wdata)))
    else $error("window write did not reach pointed location");
endmodule : mmbd_top

// File: tb/mmbd_periph_model.sv
// Peripheral register responder behind the decoder
`timescale 1ns/1ps
module mmbd_periph_model (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_nrst,
  input  wire mmbd_pkg::mmbd_periph_t i_periph,
  output logic [7:0]                  o_rdata
);
  logic [7:0] mem_r [256];
  logic [7:0] junk_r;

  // Stored writes, so a read proves the address path
  always_ff @(posedge i_sys_clk) begin
    if (i_periph.wr) begin
      mem_r[i_periph.addr] <= i_periph.wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      junk_r <= 8'h00;
    end else begin
      junk_r <= junk_r + 8'h5b;
    end
  end

  // Idle bus shows a moving pattern, never the last answer
  assign o_rdata = i_periph.rd ? mem_r[i_periph.addr] : junk_r;
endmodule : mmbd_periph_model

// File: tb/memory_map_bank_decode_tb.sv
// Self-checking bench for the memory map and bank decoder
`timescale 1ns/1ps
module memory_map_bank_decode_tb;
  logic                   clk   = 1'b0;
  logic                   nrst  = 1'b0;
  logic                   inc   = 1'b0;
  logic                   jmp   = 1'b0;
  logic                   irq   = 1'b0;
  logic                   fwe   = 1'b0;
  logic [10:0]            tgt   = 11'h000;
  logic [2:0]             flg   = 3'h0;
  logic [1:0]             to_pd = 2'h3;
  mmbd_pkg::mmbd_dreq_t   dreq  = '0;
  logic [7:0]             prd;
  logic [12:0]            pc;
  logic [9:0]             paddr;
  logic [7:0]             rdat;
  logic [7:0]             stat;
  logic [7:0]             intc;
  mmbd_pkg::mmbd_periph_t per;
  int                     n_fail = 0;
  int                     total_checks = 0;

  // Small variant so fetch wrap is visible
  mmbd_top #(.PROG_WORDS(1024)) uut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_pc_inc(inc), .i_pc_jump(jmp),
    .i_jump_target(tgt), .i_irq_entry(irq), .i_flags_we(fwe), .i_flags(flg),
    .i_to_pd(to_pd), .i_dreq(dreq), .i_periph_rdata(prd), .o_pc(pc),
    .o_prog_addr(paddr), .o_rd_data(rdat), .o_status(stat), .o_interrupt_control(intc),
    .o_periph(per)
  );

  mmbd_periph_model peri (
    .i_sys_clk(clk), .i_nrst(nrst), .i_periph(per), .o_rdata(prd)
  );

  initial forever #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d);
    dreq = {~w, w, o, d};
    @(negedge clk);
    dreq = '0;
    @(negedge clk);
  endtask : acc

  task automatic rd(input logic [6:0] o, input logic [7:0] e);
    acc(1'b0, o, 8'h00);
    chk(rdat, e);
  endtask : rd

  // Bits are irq, jump, inc
  task automatic ctl(input logic [2:0] v);
    {irq, jmp, inc} = v;
    @(negedge clk);
    {irq, jmp, inc} = 3'h0;
    @(negedge clk);
  endtask : ctl

  task automatic t_rst;
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk(pc, 16'h0000);
    chk(stat, 16'h0018);
  endtask : t_rst

  task automatic t_fetch;
    ctl(3'h1);
    chk(pc, 16'h0001);
    ctl(3'h4);
    chk(pc, 16'h0004);
    acc(1'b1, 7'h0a, 8'hff);
    rd(7'h0a, 8'h1f);
    tgt = 11'h7ff;
    ctl(3'h2);
    chk(pc, 16'h1fff);
    chk(paddr, 16'h03ff);
    ctl(3'h1);
    chk(pc, 16'h0000);
    acc(1'b1, 7'h02, 8'h55);
    chk(pc, 16'h1f55);
    chk(paddr, 16'h0355);
    dreq = {1'b1, 1'b0, 7'h0a, 8'h00};
    inc = 1'b1;
    @(negedge clk);
    dreq = '0;
    inc = 1'b0;
    @(negedge clk);
    chk(pc, 16'h1f56);
    chk(rdat, 16'h001f);
  endtask : t_fetch

  task automatic t_data;
    acc(1'b1, 7'h20, 8'ha5);
    acc(1'b1, 7'h01, 8'h96);
    acc(1'b1, 7'h03, 8'h20);
    chk(stat, 16'h0038);
    acc(1'b1, 7'h20, 8'h5a);
    acc(1'b1, 7'h3f, 8'hc3);
    rd(7'h20, 8'h5a);
    rd(7'h3f, 8'hc3);
    rd(7'h40, 8'h00);
    acc(1'b1, 7'h04, 8'ha0);
    acc(1'b1, 7'h0b, 8'h81);
    chk(intc, 16'h0081);
    acc(1'b1, 7'h01, 8'h33);
    rd(7'h01, 8'h33);
    acc(1'b1, 7'h03, 8'h00);
    rd(7'h01, 8'h96);
    rd(7'h20, 8'ha5);
    rd(7'h04, 8'ha0);
    rd(7'h00, 8'h5a);
    acc(1'b1, 7'h00, 8'h77);
    acc(1'b1, 7'h03, 8'h20);
    rd(7'h20, 8'h77);
    acc(1'b1, 7'h03, 8'h00);
    acc(1'b1, 7'h04, 8'h00);
    rd(7'h00, 8'h00);
    rd(7'h08, 8'h00);
    // Pointer onto a peripheral, then onto the pointer's own mirror
    acc(1'b1, 7'h04, 8'h81);
    rd(7'h00, 8'h33);
    acc(1'b1, 7'h04, 8'h84);
    acc(1'b1, 7'h00, 8'h66);
    rd(7'h04, 8'h66);
    acc(1'b1, 7'h03, 8'h20);
    rd(7'h04, 8'h66);
    acc(1'b1, 7'h03, 8'h00);
    fwe = 1'b1;
    flg = 3'h5;
    to_pd = 2'h1;
    @(negedge clk);
    fwe = 1'b0;
    @(negedge clk);
    chk(stat, 16'h000d);
  endtask : t_data

  // Codes 10 and 11 break the software rule on purpose; reset recovers
  task automatic t_bank_hi;
    for (int c = 2; c < 4; c++) begin
      acc(1'b1, 7'h03, {1'b0, c[1:0], 5'h00});
      rd(7'h20, 8'h00);
      to_pd = 2'h3;
      t_rst;
    end
  endtask : t_bank_hi

  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  initial begin
    t_rst;
    t_fetch;
    t_data;
    t_bank_hi;
    print_verdict;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
endmodule : memory_map_bank_decode_tb
